// ---- verilog/pim_pkg.sv ----
// Package for the peripheral interconnect matrix: power modes, widths and signal groups.
// Assumes the power controller encodes its mode as pim_mode_t and timer, DMA and fault sources share clk_sys.
package pim_pkg;

  // Power modes seen by the matrix; standby and shutdown drive every route to zero.
  typedef enum logic [2:0] {
    PIM_RUN,
    PIM_SLEEP,
    PIM_LP_RUN,
    PIM_LP_SLEEP,
    PIM_STOP0,
    PIM_STOP1,
    PIM_STANDBY,
    PIM_SHUTDOWN
  } pim_mode_t;

  localparam int PIM_TMR_N = 2;
  localparam int PIM_LPT_N = 2;
  localparam int PIM_CMP_N = 1;
  localparam int PIM_RTC_N = 3;
  localparam int PIM_CLK_N = 6;
  localparam int PIM_CLK_SEL_W = 3;
  localparam int PIM_GPIO_N = 4;
  localparam int PIM_SYNC_STAGES = 2;

  // Sources entering the matrix.
  typedef struct packed {
    logic [PIM_TMR_N-1:0] general_timer_trgo;
    logic [PIM_TMR_N-1:0] general_timer_evt;
    logic [PIM_CMP_N-1:0] comparator_out;
    logic adc_watchdog;
    logic [PIM_RTC_N-1:0] rtc_event;
    logic clock_security_failure;
    logic cpu_hard_fault;
    logic sram_parity_err;
    logic flash_ecc_err;
    logic voltage_detector;
    logic [PIM_GPIO_N-1:0] gpio_in;
  } pim_src_t;

  // Routed destinations leaving the matrix.
  typedef struct packed {
    logic [PIM_TMR_N-1:0] general_timer_itr;
    logic [PIM_TMR_N-1:0] general_timer_etr;
    logic adc_unit_trig;
    logic adc_unit_ext_trig;
    logic dma_mem_trig;
    logic first_comparator_blank;
    logic [PIM_CMP_N-1:0] advanced_timer_cmp;
    logic [PIM_CMP_N-1:0] wide_general_timer_cmp;
    logic advanced_timer_awd;
    logic advanced_timer_break;
    logic wide_general_timer_clk;
    logic [PIM_LPT_N-1:0] low_power_timer_trig;
  } pim_dst_t;

endpackage

// ---- verilog/pim_matrix.sv ----
// Peripheral interconnect matrix: fixed routes between peripherals, gated by power mode.
// Assumes timer, DMA and fault sources run on clk_sys; comparator, RTC, clock and GPIO
// levels come from other domains and are synchronised here.
//
// Functional notes
// - Timer outputs reach timers, ADC, comparator blanking.
// - Timer event triggers DMA, never in stop.
// - Comparator feeds advanced and wide timers outside stop.
// - Comparator triggers low-power timers, stop included.
// - ADC watchdog triggers advanced timer outside stop.
// - RTC alarms and tampers trigger low-power timers.
// - Selected clock source feeds wide timer channel.
// - Faults, comparator, voltage detector drive break.
// - Stop keeps only low-power timer routes alive.
`timescale 1ns/1ns

module pim_matrix #(
  parameter int CLK_SRC_N = pim_pkg::PIM_CLK_N
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire pim_pkg::pim_mode_t power_mode,
  input wire pim_pkg::pim_src_t src,
  input wire logic [CLK_SRC_N-1:0] clk_src_level,
  input wire logic [pim_pkg::PIM_CLK_SEL_W-1:0] clk_src_sel,
  output pim_pkg::pim_dst_t dst
);
  import pim_pkg::*;

  // Elaboration checks: refuse sizes that the fixed route table cannot serve.
  if (CLK_SRC_N < 1 || CLK_SRC_N > (1 << PIM_CLK_SEL_W)) begin : g_bad_clk_src_n
    $error("CLK_SRC_N does not fit the clock selector");
  end
  if (PIM_TMR_N != 2) begin : g_bad_tmr_n
    $error("Timer chaining crosses exactly two general timers");
  end
  if (PIM_CMP_N < 1 || PIM_RTC_N < 1 || PIM_LPT_N < 1) begin : g_bad_lp_n
    $error("Low-power timer routes need a comparator, an RTC event and a low-power timer");
  end
  if (PIM_GPIO_N <= PIM_TMR_N) begin : g_bad_gpio_n
    $error("GPIO lines must cover the timer triggers and a separate low-power timer trigger");
  end

  localparam int ASYNC_W = PIM_CMP_N + PIM_RTC_N + PIM_GPIO_N + CLK_SRC_N;
  // Width of the destination group and the mask of its low-power timer field, the lowest bits.
  localparam int DST_W = $bits(pim_dst_t);
  localparam logic [DST_W-1:0] LPT_MASK = {{(DST_W-PIM_LPT_N){1'b0}}, {PIM_LPT_N{1'b1}}};

  logic [ASYNC_W-1:0] async_in;
  logic [ASYNC_W-1:0] meta_r;
  logic [ASYNC_W-1:0] sync_r;
  logic [PIM_CMP_N-1:0] cmp_s;
  logic [PIM_RTC_N-1:0] rtc_s;
  logic [PIM_GPIO_N-1:0] gpio_s;
  logic [CLK_SRC_N-1:0] clk_s;
  logic run_class;
  logic stop_class;
  logic lp_ok;
  logic sel_clk;
  logic gpio_any;
  logic break_any;
  logic trgo_any;
  logic evt_any;
  pim_dst_t dst_nxt;
  pim_dst_t dst_r;
  logic [DST_W-1:0] dst_bits;

  // Levels from foreign domains pass two flops; only sync_r is read further on.
  assign async_in = {clk_src_level, src.gpio_in, src.rtc_event, src.comparator_out};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign cmp_s = sync_r[PIM_CMP_N-1:0];
  assign rtc_s = sync_r[PIM_CMP_N +: PIM_RTC_N];
  assign gpio_s = sync_r[PIM_CMP_N+PIM_RTC_N +: PIM_GPIO_N];
  assign clk_s = sync_r[ASYNC_W-1 -: CLK_SRC_N];

  // Mode classes: full routes run down to low-power sleep, stop keeps low-power timer routes.
  assign run_class = (power_mode == PIM_RUN) || (power_mode == PIM_SLEEP) ||
                     (power_mode == PIM_LP_RUN) || (power_mode == PIM_LP_SLEEP);
  assign stop_class = (power_mode == PIM_STOP0) || (power_mode == PIM_STOP1);
  assign lp_ok = run_class || stop_class;

  // Clock measurement selector; an out-of-range selection yields a quiet zero.
  assign sel_clk = (32'(clk_src_sel) < CLK_SRC_N) ? clk_s[clk_src_sel] : 1'b0;

  // Any-of reductions that feed the shared triggers.
  assign trgo_any = |src.general_timer_trgo;
  assign evt_any = |src.general_timer_evt;
  assign gpio_any = |gpio_s;
  assign break_any = src.clock_security_failure | src.cpu_hard_fault | src.sram_parity_err |
                     src.flash_ecc_err | cmp_s[0] | src.voltage_detector;

  // Route table; every destination is gated by the class of power mode it may work in.
  always_comb begin
    dst_nxt = '0;
    if (run_class) begin
      dst_nxt.general_timer_itr = {src.general_timer_trgo[0], src.general_timer_trgo[PIM_TMR_N-1]};
      dst_nxt.adc_unit_trig = trgo_any;
      dst_nxt.first_comparator_blank = src.general_timer_trgo[0];
      dst_nxt.dma_mem_trig = evt_any;
      dst_nxt.advanced_timer_cmp = cmp_s;
      dst_nxt.wide_general_timer_cmp = cmp_s;
      dst_nxt.advanced_timer_awd = src.adc_watchdog;
      dst_nxt.wide_general_timer_clk = sel_clk;
      dst_nxt.advanced_timer_break = break_any;
      dst_nxt.general_timer_etr = gpio_s[PIM_TMR_N-1:0];
      dst_nxt.adc_unit_ext_trig = gpio_any;
    end
    if (lp_ok) begin
      dst_nxt.low_power_timer_trig = {PIM_LPT_N{cmp_s[0] | (|rtc_s) | gpio_s[PIM_GPIO_N-1]}};
    end
  end

  // Registered outputs keep every destination glitch-free.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dst_r <= '0;
    end else begin
      dst_r <= dst_nxt;
    end
  end

  assign dst = dst_r;
  // Flat view of the outputs for the whole-group checks below.
  assign dst_bits = dst_r;

  // Assertions guarding the mode gating and the routes. Each output is compared with what its
  // inputs held one edge earlier. Checks that expect a one also need that earlier edge to be out
  // of reset, since the first edge after release still shows the reset value.

  // Timer outputs: chaining crosses the two timers, then the ADC trigger and comparator blanking.
  a_tmr_chain_cross: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(run_class)) |->
      (dst.general_timer_itr[0] == $past(src.general_timer_trgo[1])) &&
      (dst.general_timer_itr[1] == $past(src.general_timer_trgo[0])))
    else $error("Timer chaining not crossed");
  a_tmr_adc_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(run_class)) |-> dst.adc_unit_trig == $past(trgo_any))
    else $error("ADC trigger not routed");
  a_tmr_blank_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(run_class)) |-> dst.first_comparator_blank == $past(src.general_timer_trgo[0]))
    else $error("Comparator blanking not routed");

  // DMA trigger: routed in the run class, silent in every other mode.
  a_dma_evt_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(run_class)) |-> dst.dma_mem_trig == $past(evt_any))
    else $error("DMA trigger not routed");
  a_dma_stop_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(run_class) |-> !dst.dma_mem_trig)
    else $error("DMA trigger outside run class");

  // Comparator towards the advanced and the wide timer.
  a_cmp_tmr_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(run_class)) |->
      (dst.advanced_timer_cmp == $past(cmp_s)) && (dst.wide_general_timer_cmp == $past(cmp_s)))
    else $error("Comparator not routed");

  // The comparator trigger of the low-power timers survives both stop modes.
  a_lpt_cmp_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(stop_class) && $past(cmp_s[0])) |-> &dst.low_power_timer_trig)
    else $error("Comparator lost in stop");

  // ADC watchdog towards the advanced timer, only outside stop.
  a_awd_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(run_class)) |-> dst.advanced_timer_awd == $past(src.adc_watchdog))
    else $error("Watchdog trigger not routed");
  a_awd_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(stop_class) |-> !dst.advanced_timer_awd)
    else $error("Watchdog route alive in stop");

  // RTC alarms and tampers towards the low-power timers, stop modes included.
  a_rtc_lpt_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(lp_ok) && ($past(rtc_s) != '0)) |-> &dst.low_power_timer_trig)
    else $error("RTC event lost");

  // Clock measurement: the selected source, and a quiet zero for a selection out of range.
  a_clk_meas_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(run_class)) |-> dst.wide_general_timer_clk == $past(sel_clk))
    else $error("Clock select wrong");
  a_clk_meas_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(clk_src_sel) >= CLK_SRC_N) |-> !dst.wide_general_timer_clk)
    else $error("Clock select out of range not quiet");

  // Break sources flash ECC, hard fault and voltage detector, each of them enough on its own.
  a_break_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(run_class) && $past(src.flash_ecc_err)) |-> dst.advanced_timer_break)
    else $error("Break missed");
  a_break_hard_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(run_class) && $past(src.cpu_hard_fault)) |-> dst.advanced_timer_break)
    else $error("Break missed on hard fault");
  a_break_voltage: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(run_class) && $past(src.voltage_detector)) |-> dst.advanced_timer_break)
    else $error("Break missed on voltage detector");

  // Stop keeps only the low-power timer field; standby and shutdown keep nothing at all.
  a_stop_only_lpt: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(stop_class) |-> (dst_bits & ~LPT_MASK) == '0)
    else $error("Non low-power route alive in stop");
  a_deep_all_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(power_mode) inside {PIM_STANDBY, PIM_SHUTDOWN}) |-> dst_bits == '0)
    else $error("Route alive in standby or shutdown");

  // GPIO triggers towards the timers, the ADC and the low-power timers.
  a_gpio_adc_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(run_class)) |-> dst.adc_unit_ext_trig == $past(gpio_any))
    else $error("GPIO ADC trigger wrong");
  a_gpio_etr_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(run_class)) |-> dst.general_timer_etr == $past(gpio_s[PIM_TMR_N-1:0]))
    else $error("GPIO timer trigger wrong");
  a_gpio_lpt_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(lp_ok) && $past(gpio_s[PIM_GPIO_N-1])) |-> &dst.low_power_timer_trig)
    else $error("GPIO low-power trigger lost");

  // Main scenarios worth seeing: break in run, low-power trigger in stop, DMA trigger,
  // a step down into stop, and a watchdog trigger in low-power run.
  c_break_run: cover property (@(posedge clk_sys) disable iff (!rst_n) run_class ##1 dst.advanced_timer_break);
  c_lpt_stop: cover property (@(posedge clk_sys) disable iff (!rst_n) stop_class ##1 dst.low_power_timer_trig[0]);
  c_dma_trig: cover property (@(posedge clk_sys) disable iff (!rst_n) dst.dma_mem_trig);
  c_mode_to_stop: cover property (@(posedge clk_sys) disable iff (!rst_n) run_class ##1 stop_class);
  c_awd_lp_run: cover property (@(posedge clk_sys) disable iff (!rst_n)
    (power_mode == PIM_LP_RUN) ##1 dst.advanced_timer_awd);

endmodule

// ---- tb/pim_peer.sv ----
// Peer peripherals model: drives the matrix sources and the raw clock levels.
// Assumes the bench sets the wanted levels; they reach the pins 1 ns after an edge.
`timescale 1ns/1ns
module pim_peer (
  input wire logic clk_sys,
  input wire pim_pkg::pim_src_t want,
  input wire logic [5:0] want_clk,
  output pim_pkg::pim_src_t src,
  output logic [5:0] clk_src_level
);
  import pim_pkg::*;
  // Sources start idle at time zero.
  initial begin
    src = '0;
    clk_src_level = '0;
  end
  // Levels change just after the rising edge, as peripheral logic would.
  always @(posedge clk_sys) begin
    src <= #1 want;
    clk_src_level <= #1 want_clk;
  end
endmodule

// ---- tb/tb_top.sv ----
// Testbench for the interconnect matrix: drives sources in every power mode.
// Assumes the peer model and the matrix share clk_sys at 125 MHz.
`timescale 1ns/1ns
module tb_top;
  import pim_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  pim_mode_t power_mode = PIM_RUN;
  pim_src_t want = '0;
  logic [5:0] want_clk = 6'h00;
  logic [2:0] clk_src_sel = 3'h0;
  pim_src_t src;
  logic [5:0] clk_src_level;
  pim_dst_t dst;
  int fails = 0;
  int checks_done = 0;
  // The clock toggles every half period of 4 ns.
  always #4 clk_sys = ~clk_sys;
  pim_peer i_pim_peer(.clk_sys(clk_sys), .want(want), .want_clk(want_clk), .src(src), .clk_src_level(clk_src_level));
  pim_matrix i_pim_matrix(.clk_sys(clk_sys), .rst_n(rst_n), .power_mode(power_mode), .src(src),
    .clk_src_level(clk_src_level), .clk_src_sel(clk_src_sel), .dst(dst));
  // Expected outputs: run-class routes live up to low-power sleep, low-power timer routes up to stop 1.
  function automatic pim_dst_t model(pim_mode_t m, pim_src_t s, logic [5:0] lv, logic [2:0] sel);
    pim_dst_t d;
    logic run;
    logic lp;
    run = (m <= PIM_LP_SLEEP);
    lp = (m <= PIM_STOP1);
    d.general_timer_itr = {s.general_timer_trgo[0], s.general_timer_trgo[1]} & {2{run}};
    d.general_timer_etr = s.gpio_in[1:0] & {2{run}};
    d.adc_unit_trig = run & |s.general_timer_trgo;
    d.adc_unit_ext_trig = run & |s.gpio_in;
    d.dma_mem_trig = run & |s.general_timer_evt;
    d.first_comparator_blank = run & s.general_timer_trgo[0];
    d.advanced_timer_cmp = run & s.comparator_out;
    d.wide_general_timer_cmp = run & s.comparator_out;
    d.advanced_timer_awd = run & s.adc_watchdog;
    d.advanced_timer_break = run & (s.clock_security_failure | s.cpu_hard_fault | s.sram_parity_err
      | s.flash_ecc_err | s.comparator_out[0] | s.voltage_detector);
    d.wide_general_timer_clk = run & (sel < 3'h6) & ((sel < 3'h6) ? lv[sel] : 1'b0);
    d.low_power_timer_trig = {2{lp & (s.comparator_out[0] | (|s.rtc_event) | s.gpio_in[3])}};
    return d;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Applies one setting, lets the synchronisers flush, then compares every route.
  task automatic apply(pim_mode_t m, pim_src_t s, logic [5:0] lv, logic [2:0] sel, string what);
    power_mode = m;
    want = s;
    want_clk = lv;
    clk_src_sel = sel;
    repeat (5) @(posedge clk_sys);
    #1;
    check(what, 32'(dst), 32'(model(m, s, lv, sel)));
  endtask
  // Each source alone in each mode, so a crossed or ungated route shows up.
  task automatic t_sources();
    pim_src_t s;
    for (int m = 0; m < 8; m++) begin
      for (int b = 0; b < $bits(pim_src_t); b++) begin
        s = '0;
        s[b] = 1'b1;
        apply(pim_mode_t'(m), s, 6'h00, 3'h0, "one source");
      end
      apply(pim_mode_t'(m), '1, 6'h3F, 3'h2, "all sources");
    end
  endtask
  // Every clock select, out-of-range ones too, inside and outside stop.
  task automatic t_clocks();
    for (int k = 0; k < 8; k++) begin
      apply(PIM_LP_RUN, '0, 6'h15, 3'(k), "clock select");
      apply(PIM_STOP0, '0, 6'h2A, 3'(k), "clock in stop");
    end
  endtask
  task automatic complete_run();
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence: reset for two cycles, then the scenarios.
  initial begin
    @(posedge clk_sys);
    #1;
    check("reset", 32'(dst), 32'h0);
    @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_sources();
    t_clocks();
    complete_run();
  end
  // The run needs about 840 cycles; this cuts a hang short.
  initial begin
    #30000;
    fails++;
    complete_run();
  end
endmodule
